// file: thermal_alarm_pkg.sv
package thermal_alarm_pkg;

	// register map
	localparam logic [7:0] REG_LTEMP   = 8'h00;
	localparam logic [7:0] REG_RTEMP_H = 8'h01;
	localparam logic [7:0] REG_STATUS  = 8'h02;
	localparam logic [7:0] REG_CFG     = 8'h09;
	localparam logic [7:0] REG_RATE    = 8'h0a;
	localparam logic [7:0] REG_LHI     = 8'h0b;
	localparam logic [7:0] REG_LLO     = 8'h0c;
	localparam logic [7:0] REG_RHI     = 8'h0d;
	localparam logic [7:0] REG_RLO     = 8'h0e;
	localparam logic [7:0] REG_MODE    = 8'h0f;
	localparam logic [7:0] REG_RTEMP_L = 8'h10;
	localparam logic [7:0] REG_REMOTE_CRIT_FLAG   = 8'h19;
	localparam logic [7:0] REG_LOCAL_CRIT_FLAG   = 8'h20;
	localparam logic [7:0] REG_HYST    = 8'h21;

	// field positions
	localparam int CFG_FQ_BIT    = 0;
	localparam int CFG_MASK_BIT  = 7;
	localparam int MODE_CMP_BIT  = 0;
	localparam int ST_BUSY_BIT   = 7;
	localparam int ST_LHI_BIT    = 6;
	localparam int ST_LLO_BIT    = 5;
	localparam int ST_RHI_BIT    = 4;
	localparam int ST_RLO_BIT    = 3;
	localparam int ST_OPEN_BIT   = 2;
	localparam int ST_REMOTE_CRIT_FLAG_BIT  = 1;
	localparam int ST_LOCAL_CRIT_FLAG_BIT  = 0;
	localparam logic [7:0] ALARM_BITS = 8'h7b;

	typedef struct packed {
		logic [7:0] high;
		logic [7:0] low;
		logic [7:0] crit;
	} limits_t;

	// reset values
	localparam logic [7:0] CFG_RST   = 8'h00;
	localparam logic [7:0] RATE_RST  = 8'h00;
	localparam logic [7:0] MODE_RST  = 8'h00;
	localparam logic [7:0] HYST_RST  = 8'h0a;
	localparam limits_t    LIM_RST   = '{high: 8'h46, low: 8'h00, crit: 8'h55};

	// substituted remote readings on diode faults
	localparam logic [7:0] TEMP_OPEN  = 8'h7f;
	localparam logic [7:0] TEMP_SHORT = 8'h80;
	localparam logic [7:0] TEMP_ZERO  = 8'h00;

	localparam logic [1:0] FQ_LAST = 2'h2;

	// timing
	localparam int CLK_MHZ         = 125;
	localparam int MEAS_TIME_US    = 38000;
	localparam int MEAS_CYC        = MEAS_TIME_US * CLK_MHZ;
	localparam int TIMEOUT_TIME_US = 35000;
	localparam int TIMEOUT_CYC     = TIMEOUT_TIME_US * CLK_MHZ;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_ADDR    = 3'b001,
		ST_CMD     = 3'b010,
		ST_WDATA   = 3'b011,
		ST_ACK_OUT = 3'b100,
		ST_RDATA   = 3'b101,
		ST_ACK_IN  = 3'b110
	} smb_state_t;

endpackage : thermal_alarm_pkg

// file: thermal_alarm_smbus_slave.sv
// Contract
// R1: crit pin low while reading above setpoint
// R2: crit exceed sets remote/local crit flag
// R3: flags and crit pin update per conversion
// R4: crit release below setpoint minus hysteresis
// R5: interrupt mode: only status read clears flags
// R6: fault queue needs three consecutive violations
// R7: fault queue off at reset, config bit0
// R8: queued crit release needs three low samples
// R9: alert releases after one in-limit sample
// R10: open diode loads +127, zero, open flag
// R11: open diode trips limits via comparison
// R12: open flag alone never drives alert
// R13: shorted diode loads -128, no open flag
// R14: shorted diode trips low limit compare
// R15: only write/read/receive/send byte supported
// R16: nine clocks per byte, MSB first, ack
// R17: acknowledge only the fixed bus address
// R18: command byte becomes register pointer
// R19: receive byte returns pointed register
// R20: clock and data low timeout resets slave
// R21: host holds clock low 35 ms minimum
// R22: start recovers slave, expects address next
// R23: alert follows alarm flags unless masked
// R24: alert_mode selects comparator or interrupt
// R25: status register readable at 02h
// R26: fault counter clears on in-limit sample
// R27: conversions alternate channels with done strobe
module thermal_alarm_smbus_slave
	import thermal_alarm_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR_P     = 7'h2a, // arbitrary value
	parameter int         MEAS_CYC_P     = MEAS_CYC,
	parameter int         TIMEOUT_CYC_P  = TIMEOUT_CYC
)(
	input  wire logic       clk_sys_in,
	input  wire logic       srst_in,
	input  wire logic       serial_clock_pin_in,
	input  wire logic       serial_data_pin_in,
	output logic            serial_data_pin_out,
	output logic            serial_data_pin_oe_out,
	output logic            alert_n_out,
	output logic            alert_oe_out,
	output logic            critical_temp_output_n_out,
	output logic            critical_temp_output_oe_out,
	input  wire logic [7:0] local_temp_in,
	input  wire logic [7:0] remote_temp_hi_in,
	input  wire logic [7:0] remote_temp_lo_in,
	input  wire logic       diode_open_in,
	input  wire logic       diode_short_in
);

	localparam int MEAS_W = $clog2(MEAS_CYC_P + 1);
	localparam int TO_W   = $clog2(TIMEOUT_CYC_P + 2);

	logic [2:0]  scl_s_q, sda_s_q;
	logic        scl_f_q, sda_f_q, scl_p_q, sda_p_q;
	logic        scl_rise_w, scl_fall_w, start_w, stop_w, to_hit_w, fsm_go_w;
	logic [TO_W-1:0] to_cnt_q;
	smb_state_t  st_q, next_q;
	logic [7:0]  shift_q, ptr_q, rd_data_w;
	logic [3:0]  bit_cnt_q;
	logic        ack_q, wr_en_w, stat_rd_w, rd_clr_w, mask_set_w;
	logic [7:0]  cfg_q, rate_q, mode_q, hyst_q, status_w;
	limits_t     lim_q [0:1];
	logic [7:0]  local_temp_q, rtemp_hi_q, rtemp_lo_q;
	logic [MEAS_W-1:0] meas_cnt_q;
	logic [7:0]  slot_q;
	logic        conv_ch_q, conv_done_w, cmp_mode_w, fq_en_w, open_flag_q;
	logic [7:0]  meas_w [0:1];
	logic [1:0]  strobe_w, qual_cr_w, act_cr_w, act_hi_w, act_lo_w, cond_hi_w, cond_lo_w;
	logic [1:0]  rel_w, hi_flag_w, lo_flag_w, cr_flag_w;
	logic [1:0]  cnt_hi_w [0:1];
	logic        alert_oe_q, crit_oe_q;

	assign cmp_mode_w = mode_q[MODE_CMP_BIT];
	assign fq_en_w    = cfg_q[CFG_FQ_BIT];

	// pin synchronisers: the filtered level moves only when stages 2 and 3 agree
	always_ff @(posedge clk_sys_in)
	begin
		if (srst_in)
		begin
			scl_s_q <= 3'h7;
			sda_s_q <= 3'h7;
			scl_f_q <= 1'b1;
			sda_f_q <= 1'b1;
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end
		else
		begin
			scl_s_q <= {scl_s_q[1:0], serial_clock_pin_in};
			sda_s_q <= {sda_s_q[1:0], serial_data_pin_in};
			if (scl_s_q[1] == scl_s_q[2])
				scl_f_q <= scl_s_q[2];
			if (sda_s_q[1] == sda_s_q[2])
				sda_f_q <= sda_s_q[2];
			scl_p_q <= scl_f_q;
			sda_p_q <= sda_f_q;
		end
	end

	assign scl_rise_w = scl_f_q & ~scl_p_q;
	assign scl_fall_w = ~scl_f_q & scl_p_q;
	assign start_w    = ~sda_f_q & sda_p_q & scl_f_q & scl_p_q;
	assign stop_w     = sda_f_q & ~sda_p_q & scl_f_q & scl_p_q;
	assign to_hit_w   = (to_cnt_q == TO_W'(TIMEOUT_CYC_P + 1));
	assign fsm_go_w   = ~to_hit_w & ~start_w & ~stop_w;

	// bus timeout: counts only while both lines sit low
	always_ff @(posedge clk_sys_in)
	begin
		if (srst_in || scl_f_q || sda_f_q || to_hit_w)
			to_cnt_q <= '0;
		else
			to_cnt_q <= to_cnt_q + TO_W'(1); // [R20]
	end

	// byte engine: 8 bits MSB first, ninth clock is the acknowledge [R16]
	always_ff @(posedge clk_sys_in)
	begin
		if (srst_in || to_hit_w)
		begin
			st_q      <= ST_IDLE; // [R20]
			next_q    <= ST_IDLE;
			ack_q     <= 1'b0;
			bit_cnt_q <= 4'h0;
			shift_q   <= 8'h00;
		end
		else if (start_w)
		begin
			st_q      <= ST_ADDR; // [R22]
			ack_q     <= 1'b0;
			bit_cnt_q <= 4'h0;
		end
		else if (stop_w)
		begin
			st_q  <= ST_IDLE;
			ack_q <= 1'b0;
		end
		else
		begin
			unique case (st_q)
				ST_IDLE:
					;
				ST_ADDR, ST_CMD, ST_WDATA:
				begin
					if (scl_rise_w && bit_cnt_q < 4'h8)
					begin
						shift_q   <= {shift_q[6:0], sda_f_q};
						bit_cnt_q <= bit_cnt_q + 4'h1;
					end
					else if (scl_fall_w && bit_cnt_q == 4'h8)
					begin
						if (st_q == ST_ADDR && shift_q[7:1] != DEV_ADDR_P)
							st_q <= ST_IDLE; // [R17]
						else
						begin
							ack_q <= 1'b1;
							st_q  <= ST_ACK_OUT;
							if (st_q == ST_ADDR)
								next_q <= shift_q[0] ? ST_RDATA : ST_CMD; // [R15]
							else if (st_q == ST_CMD)
								next_q <= ST_WDATA;
							else
								next_q <= ST_IDLE;
						end
					end
				end
				ST_ACK_OUT:
				begin
					if (scl_fall_w)
					begin
						ack_q     <= 1'b0;
						bit_cnt_q <= 4'h0;
						st_q      <= next_q;
						if (next_q == ST_RDATA)
							shift_q <= rd_data_w; // [R19]
					end
				end
				ST_RDATA:
				begin
					if (scl_fall_w)
					begin
						if (bit_cnt_q == 4'h7)
							st_q <= ST_ACK_IN;
						else
						begin
							shift_q   <= {shift_q[6:0], 1'b0};
							bit_cnt_q <= bit_cnt_q + 4'h1;
						end
					end
				end
				ST_ACK_IN:
				begin
					// single-byte protocols only: master ack or nack both end the read
					if (scl_rise_w)
						st_q <= ST_IDLE;
				end
			endcase
		end
	end

	// pointer is taken from the command byte at its acknowledge
	always_ff @(posedge clk_sys_in)
	begin
		if (srst_in)
			ptr_q <= REG_LTEMP;
		else if (fsm_go_w && st_q == ST_CMD && scl_fall_w && bit_cnt_q == 4'h8)
			ptr_q <= shift_q; // [R18]
	end

	assign wr_en_w    = fsm_go_w && st_q == ST_WDATA && scl_fall_w && bit_cnt_q == 4'h8;
	assign stat_rd_w  = fsm_go_w && st_q == ST_ACK_OUT && scl_fall_w && next_q == ST_RDATA
		&& ptr_q == REG_STATUS; // [R25]
	assign rd_clr_w   = stat_rd_w & ~cmp_mode_w; // [R5]
	assign mask_set_w = rd_clr_w && ((status_w & ALARM_BITS) != 8'h00); // [R24]

	assign serial_data_pin_out    = 1'b0;
	assign serial_data_pin_oe_out = ack_q | (st_q == ST_RDATA && !shift_q[7]);

	always_comb
	begin
		rd_data_w = 8'h00;
		case (ptr_q)
			REG_LTEMP:   rd_data_w = local_temp_q;
			REG_RTEMP_H: rd_data_w = rtemp_hi_q;
			REG_RTEMP_L: rd_data_w = rtemp_lo_q;
			REG_STATUS:  rd_data_w = status_w;
			REG_CFG:     rd_data_w = cfg_q;
			REG_RATE:    rd_data_w = rate_q;
			REG_MODE:    rd_data_w = mode_q;
			REG_LHI:     rd_data_w = lim_q[0].high;
			REG_LLO:     rd_data_w = lim_q[0].low;
			REG_LOCAL_CRIT_FLAG:   rd_data_w = lim_q[0].crit;
			REG_RHI:     rd_data_w = lim_q[1].high;
			REG_RLO:     rd_data_w = lim_q[1].low;
			REG_REMOTE_CRIT_FLAG:   rd_data_w = lim_q[1].crit;
			REG_HYST:    rd_data_w = hyst_q;
			default:     rd_data_w = 8'h00;
		endcase
	end

	// writable registers; read-only and unmapped writes are dropped
	always_ff @(posedge clk_sys_in)
	begin
		if (srst_in)
		begin
			cfg_q    <= CFG_RST; // [R7]
			rate_q   <= RATE_RST;
			mode_q   <= MODE_RST;
			hyst_q   <= HYST_RST;
			lim_q[0] <= LIM_RST;
			lim_q[1] <= LIM_RST;
		end
		else
		begin
			if (wr_en_w)
			begin
				case (ptr_q)
					REG_CFG:   cfg_q         <= shift_q; // [R7]
					REG_RATE:  rate_q        <= shift_q;
					REG_MODE:  mode_q        <= shift_q; // [R24]
					REG_HYST:  hyst_q        <= shift_q;
					REG_LHI:   lim_q[0].high <= shift_q;
					REG_LLO:   lim_q[0].low  <= shift_q;
					REG_LOCAL_CRIT_FLAG: lim_q[0].crit <= shift_q;
					REG_RHI:   lim_q[1].high <= shift_q;
					REG_RLO:   lim_q[1].low  <= shift_q;
					REG_REMOTE_CRIT_FLAG: lim_q[1].crit <= shift_q;
					default:   ;
				endcase
			end
			if (mask_set_w)
				cfg_q[CFG_MASK_BIT] <= 1'b1; // [R24]
		end
	end

	// conversion sequencer: rate register adds idle measurement slots
	assign conv_done_w = (meas_cnt_q == MEAS_W'(MEAS_CYC_P - 1)) && (slot_q >= rate_q);

	always_ff @(posedge clk_sys_in)
	begin
		if (srst_in)
		begin
			meas_cnt_q <= '0;
			slot_q     <= 8'h00;
			conv_ch_q  <= 1'b0;
		end
		else if (meas_cnt_q == MEAS_W'(MEAS_CYC_P - 1))
		begin
			meas_cnt_q <= '0;
			slot_q     <= conv_done_w ? 8'h00 : slot_q + 8'h01;
			if (conv_done_w)
				conv_ch_q <= ~conv_ch_q; // [R27]
		end
		else
			meas_cnt_q <= meas_cnt_q + MEAS_W'(1);
	end

	assign meas_w[0] = local_temp_in;
	assign meas_w[1] = diode_open_in ? TEMP_OPEN :
		(diode_short_in ? TEMP_SHORT : remote_temp_hi_in); // [R10] [R13]

	always_ff @(posedge clk_sys_in)
	begin
		if (srst_in)
		begin
			local_temp_q <= 8'h00;
			rtemp_hi_q   <= 8'h00;
			rtemp_lo_q   <= 8'h00;
			open_flag_q  <= 1'b0;
		end
		else
		begin
			if (strobe_w[0])
				local_temp_q <= meas_w[0];
			if (strobe_w[1])
			begin
				rtemp_hi_q <= meas_w[1];
				rtemp_lo_q <= (diode_open_in || diode_short_in) ? TEMP_ZERO : remote_temp_lo_in;
			end
			// open flag: set wins over the clearing status read
			if (strobe_w[1] && (cmp_mode_w || diode_open_in))
				open_flag_q <= diode_open_in; // [R10] [R13]
			else if (rd_clr_w)
				open_flag_q <= 1'b0;
		end
	end

	for (genvar ch = 0; ch < 2; ch++)
	begin : ch_g
		limits_t    lim;
		logic [7:0] t;
		logic       cond_hi, cond_lo, cond_cr, rel, q_hi, q_lo, q_cr, q_rel;
		logic       act_hi_d, act_lo_d, act_cr_d;
		logic       act_hi_q, act_lo_q, act_cr_q, flg_hi_q, flg_lo_q, flg_cr_q;
		logic [1:0] c_hi_q, c_lo_q, c_cr_q, c_rel_q;

		assign lim     = lim_q[ch];
		assign t       = meas_w[ch];
		assign cond_hi = $signed(t) > $signed(lim.high); // [R11]
		assign cond_lo = $signed(t) < $signed(lim.low); // [R14]
		assign cond_cr = $signed(t) > $signed(lim.crit); // [R1]
		assign rel     = $signed({{2{t[7]}}, t})
			< ($signed({{2{lim.crit[7]}}, lim.crit}) - $signed({2'b00, hyst_q})); // [R4]
		assign q_hi    = cond_hi && (!fq_en_w || c_hi_q >= FQ_LAST); // [R6]
		assign q_lo    = cond_lo && (!fq_en_w || c_lo_q >= FQ_LAST); // [R6]
		assign q_cr    = cond_cr && (!fq_en_w || c_cr_q >= FQ_LAST); // [R6]
		assign q_rel   = rel && (!fq_en_w || c_rel_q >= FQ_LAST); // [R8]
		assign act_hi_d = q_hi | (cond_hi & act_hi_q); // [R9]
		assign act_lo_d = q_lo | (cond_lo & act_lo_q); // [R9]
		assign act_cr_d = q_cr | (~q_rel & act_cr_q); // [R4] [R8]

		always_ff @(posedge clk_sys_in)
		begin
			if (srst_in)
			begin
				c_hi_q   <= 2'h0;
				c_lo_q   <= 2'h0;
				c_cr_q   <= 2'h0;
				c_rel_q  <= 2'h0;
				act_hi_q <= 1'b0;
				act_lo_q <= 1'b0;
				act_cr_q <= 1'b0;
			end
			else if (strobe_w[ch])
			begin
				// an in-limit sample restarts each fault count; a sample not below crit minus hysteresis restarts c_rel_q
				c_hi_q   <= cond_hi ? ((c_hi_q < FQ_LAST) ? c_hi_q + 2'h1 : c_hi_q) : 2'h0; // [R26]
				c_lo_q   <= cond_lo ? ((c_lo_q < FQ_LAST) ? c_lo_q + 2'h1 : c_lo_q) : 2'h0; // [R26]
				c_cr_q   <= cond_cr ? ((c_cr_q < FQ_LAST) ? c_cr_q + 2'h1 : c_cr_q) : 2'h0; // [R26]
				c_rel_q  <= rel ? ((c_rel_q < FQ_LAST) ? c_rel_q + 2'h1 : c_rel_q) : 2'h0;
				act_hi_q <= act_hi_d; // [R3]
				act_lo_q <= act_lo_d;
				act_cr_q <= act_cr_d;
			end
		end

		// interrupt mode flags are sticky; a new violation beats the read clear
		always_ff @(posedge clk_sys_in)
		begin
			if (srst_in)
			begin
				flg_hi_q <= 1'b0;
				flg_lo_q <= 1'b0;
				flg_cr_q <= 1'b0;
			end
			else
			begin
				if (strobe_w[ch] && (cmp_mode_w || q_hi))
					flg_hi_q <= act_hi_d; // [R3]
				else if (rd_clr_w)
					flg_hi_q <= 1'b0; // [R5]
				if (strobe_w[ch] && (cmp_mode_w || q_lo))
					flg_lo_q <= act_lo_d;
				else if (rd_clr_w)
					flg_lo_q <= 1'b0;
				if (strobe_w[ch] && (cmp_mode_w || q_cr))
					flg_cr_q <= act_cr_d; // [R2]
				else if (rd_clr_w)
					flg_cr_q <= 1'b0; // [R5]
			end
		end

		assign strobe_w[ch]  = conv_done_w && (conv_ch_q == 1'(ch)); // [R27]
		assign qual_cr_w[ch] = q_cr;
		assign act_cr_w[ch]  = act_cr_q;
		assign act_hi_w[ch]  = act_hi_q;
		assign act_lo_w[ch]  = act_lo_q;
		assign cond_hi_w[ch] = cond_hi;
		assign cond_lo_w[ch] = cond_lo;
		assign rel_w[ch]     = rel;
		assign cnt_hi_w[ch]  = c_hi_q;
		assign hi_flag_w[ch] = flg_hi_q;
		assign lo_flag_w[ch] = flg_lo_q;
		assign cr_flag_w[ch] = flg_cr_q;
	end

	assign status_w[ST_BUSY_BIT]  = 1'b0;
	assign status_w[ST_LHI_BIT]   = hi_flag_w[0];
	assign status_w[ST_LLO_BIT]   = lo_flag_w[0];
	assign status_w[ST_RHI_BIT]   = hi_flag_w[1];
	assign status_w[ST_RLO_BIT]   = lo_flag_w[1];
	assign status_w[ST_OPEN_BIT]  = open_flag_q;
	assign status_w[ST_REMOTE_CRIT_FLAG_BIT] = cr_flag_w[1]; // [R2]
	assign status_w[ST_LOCAL_CRIT_FLAG_BIT] = cr_flag_w[0]; // [R2]

	// open-drain drivers; the open flag is kept out of the alert term
	always_ff @(posedge clk_sys_in)
	begin
		if (srst_in)
		begin
			alert_oe_q <= 1'b0;
			crit_oe_q  <= 1'b0;
		end
		else
		begin
			alert_oe_q <= ~cfg_q[CFG_MASK_BIT] && ((status_w & ALARM_BITS) != 8'h00); // [R12] [R23]
			crit_oe_q  <= |act_cr_w; // [R1]
		end
	end

	assign alert_n_out                 = 1'b0;
	assign alert_oe_out                = alert_oe_q;
	assign critical_temp_output_n_out  = 1'b0;
	assign critical_temp_output_oe_out = crit_oe_q;

	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (srst_in);

	chk_crit_pin_follow: assert property (1'b1 |=> crit_oe_q == $past(|act_cr_w)) // [R1]
		else $error("critical output does not follow crit state");
	chk_remote_crit_flag_flag_set: assert property ((strobe_w[1] && qual_cr_w[1]) |=> status_w[ST_REMOTE_CRIT_FLAG_BIT]) // [R2]
		else $error("remote crit flag not set");
	chk_flags_quiet: assert property ((!conv_done_w && !stat_rd_w) |=> $stable(status_w)) // [R3]
		else $error("status changed outside conversion or read");
	chk_crit_hyst_hold: assert property ((strobe_w[1] && act_cr_w[1] && !rel_w[1]) |=> act_cr_w[1]) // [R4]
		else $error("crit released above hysteresis point");
	chk_read_clears: assert property ((rd_clr_w && !conv_done_w) |=> status_w == 8'h00) // [R5]
		else $error("status read did not clear flags");
	chk_fq_wait_run: assert property ((fq_en_w && strobe_w[1] && cnt_hi_w[1] == 2'h0
		&& !act_hi_w[1]) |=> !act_hi_w[1]) // [R6]
		else $error("fault queue fired on first violation");
	chk_fq_por_off: assert property ($fell(srst_in) |-> !fq_en_w && !cfg_q[CFG_MASK_BIT]) // [R7]
		else $error("fault queue enabled after reset");
	chk_alert_release: assert property ((strobe_w[1] && !cond_hi_w[1] && !cond_lo_w[1])
		|=> (!act_hi_w[1] && !act_lo_w[1])) // [R9]
		else $error("limit alarm held after in-limit sample");
	chk_open_load: assert property ((strobe_w[1] && diode_open_in) |=> (rtemp_hi_q == TEMP_OPEN
		&& rtemp_lo_q == TEMP_ZERO && status_w[ST_OPEN_BIT])) // [R10]
		else $error("open diode readings not substituted");
	chk_short_load: assert property ((strobe_w[1] && diode_short_in && !diode_open_in && cmp_mode_w)
		|=> (rtemp_hi_q == TEMP_SHORT && !status_w[ST_OPEN_BIT])) // [R13]
		else $error("short diode reading wrong");
	chk_mask_alert: assert property (cfg_q[CFG_MASK_BIT] |=> !alert_oe_out) // [R23]
		else $error("alert driven while masked");
	chk_timeout_idle: assert property (to_hit_w |=> (st_q == ST_IDLE && !serial_data_pin_oe_out)) // [R20]
		else $error("timeout did not release bus");
	chk_addr_nack: assert property ((fsm_go_w && st_q == ST_ADDR && scl_fall_w && bit_cnt_q == 4'h8
		&& shift_q[7:1] != DEV_ADDR_P) |=> !ack_q ##1 !ack_q) // [R17]
		else $error("foreign address acknowledged");

	cov_status_read: cover property (stat_rd_w);
	cov_cfg_write: cover property (wr_en_w && ptr_q == REG_CFG);
	cov_timeout: cover property (to_hit_w);
	cov_crit_assert: cover property ($rose(crit_oe_q));

endmodule : thermal_alarm_smbus_slave

// file: smb_host.sv
module smb_host (
	output logic      scl_out,
	output logic      sda_oe_out,
	input  wire logic sda_in
);
	timeunit 1ns;
	timeprecision 100ps;

	initial
	begin
		scl_out    = 1'b1;
		sda_oe_out = 1'b0;
	end

	// start or repeated start: data released first, so it falls while the clock is high
	task automatic start();
		#32 sda_oe_out = 1'b0;
		#72 scl_out = 1'b1;
		#40 sda_oe_out = 1'b1;
		#40 scl_out = 1'b0;
	endtask : start

	task automatic stop();
		#32 sda_oe_out = 1'b1;
		#72 scl_out = 1'b1;
		#40 sda_oe_out = 1'b0;
		#40;
	endtask : stop

	// 104 ns low then 56 ns high; all steps are multiples of 8 ns so that,
	// started on a bench clock fall, no pin moves on the sampling edge
	task automatic clock_bit(input logic drive_low, output logic seen);
		#32 sda_oe_out = drive_low;
		#72 scl_out = 1'b1;
		seen = sda_in;
		#56 scl_out = 1'b0;
	endtask : clock_bit

	task automatic put(input logic [7:0] data, output logic ack);
		logic seen;
		for (int i = 7; i >= 0; i--)
			clock_bit(!data[i], seen);
		clock_bit(1'b0, seen);
		ack = !seen;
	endtask : put

	task automatic get(input logic last, output logic [7:0] data);
		logic seen;
		for (int i = 7; i >= 0; i--)
		begin
			clock_bit(1'b0, seen);
			data[i] = seen;
		end
		clock_bit(!last, seen);
	endtask : get

	// data left to the pull-up; the clock stays low for the whole span
	task automatic hold_low(input int ns);
		#32 sda_oe_out = 1'b0;
		#(ns);
	endtask : hold_low
endmodule : smb_host

// file: tb.sv
module tb
	import thermal_alarm_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	localparam logic [6:0] ADDR = 7'h2a; // arbitrary value

	logic       clk         = 1'b0;
	logic       srst        = 1'b1;
	logic       scl;
	logic       host_oe;
	logic       sda;
	logic       dut_sda_oe;
	logic       alert_oe;
	logic       crit_oe;
	logic       sda_out;
	logic       alert_n;
	logic       crit_n;
	logic [7:0] local_temp  = 8'h20;
	logic [7:0] remote_hi   = 8'h20;
	logic [7:0] remote_lo   = 8'h00;
	logic       diode_open  = 1'b0;
	logic       diode_short = 1'b0;
	int         fail_count  = 0;
	int         compares    = 0;
	logic [7:0] ra [5]      = '{REG_CFG, REG_STATUS, REG_HYST, REG_REMOTE_CRIT_FLAG, 8'h30};
	logic [7:0] rv [5]      = '{CFG_RST, 8'h00, HYST_RST, LIM_RST.crit, 8'h00};

	always #4 clk = ~clk;

	// both parties are open drain behind a pull-up
	assign sda = !(host_oe || dut_sda_oe);

	thermal_alarm_smbus_slave #(
		.DEV_ADDR_P    (ADDR),
		.MEAS_CYC_P    (50),
		.TIMEOUT_CYC_P (200)
	) i_dut (
		.clk_sys_in                  (clk),
		.srst_in                     (srst),
		.serial_clock_pin_in         (scl),
		.serial_data_pin_in          (sda),
		.serial_data_pin_out         (sda_out),
		.serial_data_pin_oe_out      (dut_sda_oe),
		.alert_n_out                 (alert_n),
		.alert_oe_out                (alert_oe),
		.critical_temp_output_n_out  (crit_n),
		.critical_temp_output_oe_out (crit_oe),
		.local_temp_in               (local_temp),
		.remote_temp_hi_in           (remote_hi),
		.remote_temp_lo_in           (remote_lo),
		.diode_open_in               (diode_open),
		.diode_short_in              (diode_short)
	);

	smb_host i_host (
		.scl_out    (scl),
		.sda_oe_out (host_oe),
		.sda_in     (sda)
	);

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic wait_clk(input int n);
		repeat (n) @(negedge clk);
	endtask : wait_clk

	// new remote reading, then let conversions run; at rate 0 a remote sample comes every 100 clocks
	task automatic remote_for(input logic [7:0] t, input int n);
		@(negedge clk);
		remote_hi = t;
		wait_clk(n);
	endtask : remote_for

	task automatic pins(input logic [7:0] exp);
		// open-drain levels must stay low; only the enables may move
		check({3'h0, sda_out, alert_n, crit_n, alert_oe, crit_oe}, exp);
	endtask : pins

	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		logic [2:0] ack;
		i_host.start();
		i_host.put({ADDR, 1'b0}, ack[0]);
		i_host.put(a, ack[1]);
		i_host.put(d, ack[2]);
		i_host.stop();
		check({5'h00, ack}, 8'h07);
	endtask : reg_wr

	task automatic send_byte(input logic [7:0] a);
		logic [1:0] ack;
		i_host.start();
		i_host.put({ADDR, 1'b0}, ack[0]);
		i_host.put(a, ack[1]);
		i_host.stop();
		check({6'h00, ack}, 8'h03);
	endtask : send_byte

	task automatic recv_byte(input logic [7:0] exp);
		logic       ack;
		logic [7:0] d;
		i_host.start();
		i_host.put({ADDR, 1'b1}, ack);
		i_host.get(1'b1, d);
		i_host.stop();
		check({7'h00, ack}, 8'h01);
		check(d, exp);
	endtask : recv_byte

	task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
		logic [2:0] ack;
		logic [7:0] d;
		i_host.start();
		i_host.put({ADDR, 1'b0}, ack[0]);
		i_host.put(a, ack[1]);
		i_host.start();
		i_host.put({ADDR, 1'b1}, ack[2]);
		i_host.get(1'b1, d);
		i_host.stop();
		check({5'h00, ack}, 8'h07);
		check(d, exp);
	endtask : reg_rd

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test

	initial
	begin
		#400us;
		fail_count++;
		end_of_test();
	end

	initial
	begin
		logic ack;
		wait_clk(10);
		srst = 1'b0;
		wait_clk(4);
		for (int i = 0; i < 5; i++)
			reg_rd(ra[i], rv[i]);
		i_host.start();
		i_host.put({ADDR ^ 7'h01, 1'b1}, ack);
		i_host.stop();
		check({7'h00, ack}, 8'h00);
		reg_wr(REG_RLO, 8'h05);
		reg_rd(REG_RLO, 8'h05);
		send_byte(REG_HYST);
		recv_byte(HYST_RST);
		$display("test registers done");

		remote_for(8'h60, 300);
		pins(8'h03);
		remote_for(8'h50, 300);
		pins(8'h03);
		remote_for(8'h40, 300);
		pins(8'h02);
		reg_rd(REG_STATUS, 8'h12);
		reg_rd(REG_CFG, 8'h80);
		reg_rd(REG_STATUS, 8'h00);
		pins(8'h00);
		$display("test interrupt mode done");

		reg_wr(REG_CFG, 8'h01);
		reg_wr(REG_MODE, 8'h01);
		remote_for(8'h50, 150);
		pins(8'h00);
		wait_clk(250);
		pins(8'h02);
		remote_for(8'h40, 150);
		pins(8'h00);
		remote_for(8'h60, 400);
		pins(8'h03);
		remote_for(8'h40, 150);
		pins(8'h03);
		wait_clk(250);
		pins(8'h00);
		remote_for(8'h50, 150);
		remote_for(8'h40, 150);
		remote_for(8'h50, 150);
		pins(8'h00);
		remote_for(8'h40, 300);
		$display("test fault queue done");

		reg_wr(REG_RHI, 8'h7f);
		reg_wr(REG_REMOTE_CRIT_FLAG, 8'h7f);
		@(negedge clk);
		remote_lo = 8'ha0;
		diode_open = 1'b1;
		wait_clk(400);
		reg_rd(REG_RTEMP_H, TEMP_OPEN);
		reg_rd(REG_RTEMP_L, TEMP_ZERO);
		reg_rd(REG_STATUS, 8'h04);
		pins(8'h00);
		reg_wr(REG_REMOTE_CRIT_FLAG, 8'h7e);
		wait_clk(400);
		pins(8'h03);
		@(negedge clk);
		diode_open = 1'b0;
		diode_short = 1'b1;
		wait_clk(400);
		reg_rd(REG_RTEMP_H, TEMP_SHORT);
		reg_rd(REG_STATUS, 8'h08);
		pins(8'h02);
		@(negedge clk);
		diode_short = 1'b0;
		wait_clk(400);
		$display("test diode faults done");

		// rate 1 doubles the spacing: a remote sample every 200 clocks
		reg_wr(REG_RATE, 8'h01);
		remote_for(8'h00, 350);
		pins(8'h00);
		wait_clk(350);
		pins(8'h02);
		remote_for(8'h40, 250);
		pins(8'h00);
		$display("test conversion rate done");

		// stop the clock while the slave is sending a zero bit
		i_host.start();
		i_host.put({ADDR, 1'b0}, ack);
		i_host.put(8'h30, ack);
		i_host.start();
		i_host.put({ADDR, 1'b1}, ack);
		wait_clk(10);
		check({7'h00, dut_sda_oe}, 8'h01);
		i_host.hold_low(250 * 8);
		check({7'h00, dut_sda_oe}, 8'h00);
		reg_rd(REG_CFG, 8'h01);
		$display("test bus timeout done");
		end_of_test();
	end
endmodule : tb
